// ---- rtl/msw_regs.sv ----
// Mode, supply and watchdog control registers behind a 16-bit serial frame.
// Assumes a frame decoder hands over whole frames as one-cycle strobes.
//
// Overview of operation
// - Mode field selects normal, sleep, stop, soft-reset
// - Stop to sleep mode change is refused; other bits are written
// - Restart entry forces mode to normal
// - Restart or overtemperature turns second regulator off
// - Second regulator field decodes off and three on-conditions
// - Aux enable bit turns external regulator on
// - Overvoltage flag always; restart only if enabled
// - Two-bit field selects reset threshold
// - Write frame returns previous register contents
// - Soft reset pulls reset output unless masked
// - Force bit drives failure outputs by software
// - Clearing force keeps real failures active
// - Restart entry clears software failure force
// - Battery undervoltage drops aux unless kept on
// - Load sharing and aux voltage selection bits
// - Stop-mode load sharing enable bit
// - Escalation after first or second watchdog fail
// - Soft reset keeps voltage-select and load-share
// - Watchdog control parity evaluated on write
// - Stop disable bit deactivates watchdog in stop
// - Type bit selects window or time-out watchdog
// - Bus wake in stop may start watchdog
// - Frame bit 15 selects write or read
module msw_regs (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // Serial frame, already assembled
  input wire logic i_frame_valid,
  input wire logic [15:0] i_frame,
  output logic [7:0] o_read_data,
  output logic o_read_valid,
  // Hardware events
  input wire msw_pkg::msw_events_t i_events,
  // Supply and mode outputs
  output msw_pkg::msw_mode_t o_mode,
  output msw_pkg::msw_supply_t o_supply,
  output logic o_soft_reset,
  output logic o_reset_output_pin_n,
  output logic o_failure_output_pins,
  output logic o_main_overvoltage_flag,
  // Watchdog outputs
  output msw_pkg::msw_wd_t o_wd,
  output logic o_wd_bus_wake_start
);
  import msw_pkg::*;

  logic [7:0] mode_supply_r;
  logic [7:0] hw_cfg_r;
  logic [7:0] watchdog_control_r;
  logic wr_en;
  logic [6:0] addr;
  logic [7:0] wdata;
  logic soft_rst_req;
  logic stop_to_sleep;
  logic [9:0] period_ms;
  logic period_valid;
  logic parity_ok_r;
  logic restart_d_r;
  logic ot_d_r;
  logic restart_edge;
  logic ot_edge;

  // ==========================================================================
  // Frame decode
  assign wr_en = i_frame_valid & i_frame[MSW_SPI_WRITE_BIT];
  assign addr = i_frame[14:8];
  assign wdata = i_frame[7:0];
  assign stop_to_sleep = (mode_supply_r[MSW_MODE_HI:MSW_MODE_LO] ==
      MSW_MODE_STOP) && (wdata[MSW_MODE_HI:MSW_MODE_LO] ==
      MSW_MODE_SLEEP);
  // Soft reset is a write of mode 11; it is not stored as a mode
  assign soft_rst_req = wr_en && addr == MSW_ADDR_MODE_SUPPLY &&
      wdata[MSW_MODE_HI:MSW_MODE_LO] == MSW_MODE_SOFT_RST;
  assign restart_edge = i_events.restart_entry & ~restart_d_r;
  assign ot_edge = i_events.overtemp & ~ot_d_r;

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      restart_d_r <= 1'b0;
      ot_d_r <= 1'b0;
    end else begin
      restart_d_r <= i_events.restart_entry;
      ot_d_r <= i_events.overtemp;
    end
  end

  // ==========================================================================
  // Mode and supply control register
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      mode_supply_r <= MSW_MODE_SUPPLY_RST;
    end else if (soft_rst_req) begin
      mode_supply_r <= MSW_MODE_SUPPLY_RST;
    end else begin
      if (wr_en && addr == MSW_ADDR_MODE_SUPPLY) begin
        mode_supply_r[5:0] <= wdata[5:0];
        if (!stop_to_sleep) begin
          mode_supply_r[MSW_MODE_HI:MSW_MODE_LO] <=
              wdata[MSW_MODE_HI:MSW_MODE_LO];
        end
      end
      // Hardware wins over a write landing in the same cycle
      if (restart_edge) begin
        mode_supply_r[MSW_MODE_HI:MSW_MODE_LO] <= MSW_MODE_NORMAL;
        mode_supply_r[MSW_AUX_ON_BIT] <= 1'b0;
        mode_supply_r[MSW_OV_ACT_BIT] <= 1'b0;
      end
      if (restart_edge || ot_edge) begin
        mode_supply_r[MSW_SEC_HI:MSW_SEC_LO] <= MSW_SEC_OFF;
      end
    end
  end

  // ==========================================================================
  // Hardware configuration register
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      hw_cfg_r <= MSW_HW_CFG_RST;
    end else if (soft_rst_req) begin
      hw_cfg_r <= hw_cfg_r & MSW_HW_CFG_SOFT_KEEP;
    end else begin
      if (wr_en && addr == MSW_ADDR_HW_CFG) begin
        hw_cfg_r <= wdata & MSW_HW_CFG_WMASK;
      end
      if (restart_edge) begin
        hw_cfg_r[MSW_FO_FORCE_BIT] <= 1'b0;
        hw_cfg_r[MSW_SR_MASK_BIT] <= 1'b0;
        hw_cfg_r[MSW_UV_KEEP_BIT] <= 1'b0;
        hw_cfg_r[2:1] <= 2'b00;
      end
    end
  end

  // ==========================================================================
  // Watchdog control register
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      watchdog_control_r <= MSW_WATCHDOG_CONTROL_RST;
      parity_ok_r <= 1'b1;
    end else if (soft_rst_req) begin
      watchdog_control_r <= MSW_WATCHDOG_CONTROL_RST;
      parity_ok_r <= 1'b1;
    end else if (restart_edge) begin
      watchdog_control_r <= (watchdog_control_r & MSW_WD_RESTART_KEEP) | MSW_WD_RESTART_SET;
    end else if (wr_en && addr == MSW_ADDR_WATCHDOG_CONTROL) begin
      watchdog_control_r <= wdata & MSW_WATCHDOG_CONTROL_WMASK;
      // Parity is judged on the written byte as sent
      parity_ok_r <= ~^wdata;
    end
  end

  // ==========================================================================
  // Serial answer: contents before this frame's write
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_read_data <= 8'h00;
      o_read_valid <= 1'b0;
    end else begin
      o_read_valid <= i_frame_valid;
      if (i_frame_valid) begin
        unique case (addr)
          MSW_ADDR_MODE_SUPPLY: o_read_data <= mode_supply_r;
          MSW_ADDR_HW_CFG: o_read_data <= hw_cfg_r;
          MSW_ADDR_WATCHDOG_CONTROL: o_read_data <= watchdog_control_r;
          default: o_read_data <= 8'h00;
        endcase
      end
    end
  end

  // ==========================================================================
  // Watchdog period lookup
  msw_period_rom u_period (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_code(watchdog_control_r[2:0]),
    .o_period_ms(period_ms),
    .o_valid(period_valid)
  );

  // ==========================================================================
  // Mode and reset outputs
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_mode <= MSW_MODE_NORMAL;
      o_soft_reset <= 1'b0;
      o_reset_output_pin_n <= 1'b0;
    end else begin
      o_mode <= msw_mode_t'(mode_supply_r[MSW_MODE_HI:MSW_MODE_LO]);
      o_soft_reset <= soft_rst_req;
      // Mask is sampled before the soft reset clears it
      o_reset_output_pin_n <= ~(soft_rst_req &
          ~hw_cfg_r[MSW_SR_MASK_BIT]);
    end
  end

  // ==========================================================================
  // Supply decode
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_supply <= '0;
      o_main_overvoltage_flag <= 1'b0;
    end else begin
      unique case (msw_sec_t'(mode_supply_r[MSW_SEC_HI:MSW_SEC_LO]))
        MSW_SEC_OFF: o_supply.second_regulator_on <= 1'b0;
        MSW_SEC_NORMAL: o_supply.second_regulator_on <=
            mode_supply_r[MSW_MODE_HI:MSW_MODE_LO] == MSW_MODE_NORMAL;
        MSW_SEC_NORM_STOP: o_supply.second_regulator_on <=
            mode_supply_r[MSW_MODE_HI:MSW_MODE_LO] != MSW_MODE_SLEEP;
        MSW_SEC_ALWAYS: o_supply.second_regulator_on <=
            ~i_events.fail_safe;
      endcase
      // Undervoltage shutdown unless kept on
      o_supply.aux_regulator_on <= mode_supply_r[MSW_AUX_ON_BIT] &
          (hw_cfg_r[MSW_UV_KEEP_BIT] |
          ~i_events.battery_undervoltage);
      o_supply.aux_voltage_select <= hw_cfg_r[MSW_AUX_VSEL_BIT];
      // Load sharing in stop or high power only with its enable
      o_supply.load_sharing_select <= hw_cfg_r[MSW_LS_BIT] &
          (~((mode_supply_r[MSW_MODE_HI:MSW_MODE_LO] == MSW_MODE_STOP) |
          i_events.high_power) | hw_cfg_r[MSW_STOP_LS_BIT]);
      o_supply.reset_threshold_select <= mode_supply_r[1:0];
      o_supply.overvoltage_restart_req <= i_events.main_overvoltage &
          mode_supply_r[MSW_OV_ACT_BIT];
      o_supply.escalate_first_fail <= hw_cfg_r[MSW_ESC_BIT];
      o_main_overvoltage_flag <= i_events.main_overvoltage;
    end
  end

  // ==========================================================================
  // Failure outputs: software force or the real failure input, not latched here
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_failure_output_pins <= 1'b0;
    end else begin
      o_failure_output_pins <= hw_cfg_r[MSW_FO_FORCE_BIT] |
          i_events.failure_active;
    end
  end

  // ==========================================================================
  // Watchdog controls
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_wd <= '0;
      o_wd_bus_wake_start <= 1'b0;
    end else begin
      o_wd.active <= ~((mode_supply_r[MSW_MODE_HI:MSW_MODE_LO] ==
          MSW_MODE_STOP) & watchdog_control_r[MSW_WD_STOP_DIS_BIT]);
      o_wd.window_mode <= watchdog_control_r[MSW_WATCHDOG_TYPE_SELECT_BIT];
      o_wd.start_on_bus_wake <= watchdog_control_r[MSW_WD_BUS_WAKE_BIT];
      o_wd.parity_ok <= parity_ok_r;
      o_wd.period_valid <= period_valid;
      o_wd.period_ms <= period_ms;
      o_wd_bus_wake_start <= i_events.bus_wake &
          (mode_supply_r[MSW_MODE_HI:MSW_MODE_LO] == MSW_MODE_STOP) &
          watchdog_control_r[MSW_WD_BUS_WAKE_BIT];
    end
  end
endmodule // msw_regs

// ---- rtl/msw_pkg.sv ----
// Shared constants and carriers for the mode, supply and watchdog registers.
// Assumes a single 25 MHz clock and a serial frame decoder outside the block.
package msw_pkg;
  // ==========================================================================
  // Register addresses (7-bit)
  localparam logic [6:0] MSW_ADDR_MODE_SUPPLY = 7'h01;
  localparam logic [6:0] MSW_ADDR_HW_CFG = 7'h02;
  localparam logic [6:0] MSW_ADDR_WATCHDOG_CONTROL = 7'h03;
  // ==========================================================================
  // Values after power-on and soft reset, except hw config bits kept by soft reset
  localparam logic [7:0] MSW_MODE_SUPPLY_RST = 8'h00;
  localparam logic [7:0] MSW_HW_CFG_RST = 8'h00;
  localparam logic [7:0] MSW_WATCHDOG_CONTROL_RST = 8'h14;
  // Bits kept through a soft reset in the hardware configuration register
  localparam logic [7:0] MSW_HW_CFG_SOFT_KEEP = 8'h88;
  // Writable bit masks; bit 2 of hw config and bit 3 of wd control reserved
  localparam logic [7:0] MSW_HW_CFG_WMASK = 8'hfb;
  localparam logic [7:0] MSW_WATCHDOG_CONTROL_WMASK = 8'hf7;
  // Restart keeps these watchdog control bits, low nibble forced to 4
  localparam logic [7:0] MSW_WD_RESTART_KEEP = 8'hb0;
  localparam logic [7:0] MSW_WD_RESTART_SET = 8'h04;
  // ==========================================================================
  // Field positions
  localparam int MSW_MODE_HI = 7;
  localparam int MSW_MODE_LO = 6;
  localparam int MSW_AUX_ON_BIT = 5;
  localparam int MSW_SEC_HI = 4;
  localparam int MSW_SEC_LO = 3;
  localparam int MSW_OV_ACT_BIT = 2;
  localparam int MSW_AUX_VSEL_BIT = 7;
  localparam int MSW_SR_MASK_BIT = 6;
  localparam int MSW_FO_FORCE_BIT = 5;
  localparam int MSW_UV_KEEP_BIT = 4;
  localparam int MSW_LS_BIT = 3;
  localparam int MSW_STOP_LS_BIT = 1;
  localparam int MSW_ESC_BIT = 0;
  localparam int MSW_WD_STOP_DIS_BIT = 6;
  localparam int MSW_WATCHDOG_TYPE_SELECT_BIT = 5;
  localparam int MSW_WD_BUS_WAKE_BIT = 4;
  localparam int MSW_SPI_WRITE_BIT = 15;
  // ==========================================================================
  // Watchdog period table in ms, by code
  localparam int MSW_WD_MS_0 = 10;
  localparam int MSW_WD_MS_1 = 20;
  localparam int MSW_WD_MS_2 = 50;
  localparam int MSW_WD_MS_3 = 100;
  localparam int MSW_WD_MS_4 = 200;
  localparam int MSW_WD_MS_5 = 500;
  localparam int MSW_CLK_KHZ = 25000;

  typedef enum logic [1:0] {
    MSW_MODE_NORMAL = 2'b00,
    MSW_MODE_SLEEP = 2'b01,
    MSW_MODE_STOP = 2'b10,
    MSW_MODE_SOFT_RST = 2'b11
  } msw_mode_t;

  typedef enum logic [1:0] {
    MSW_SEC_OFF = 2'b00,
    MSW_SEC_NORMAL = 2'b01,
    MSW_SEC_NORM_STOP = 2'b10,
    MSW_SEC_ALWAYS = 2'b11
  } msw_sec_t;

  // Hardware events from the rest of the chip
  typedef struct packed {
    logic restart_entry;
    logic overtemp;
    logic fail_safe;
    logic main_overvoltage;
    logic battery_undervoltage;
    logic failure_active;
    logic bus_wake;
    logic high_power;
  } msw_events_t;

  // Decoded supply controls
  typedef struct packed {
    logic second_regulator_on;
    logic aux_regulator_on;
    logic aux_voltage_select;
    logic load_sharing_select;
    logic [1:0] reset_threshold_select;
    logic overvoltage_restart_req;
    logic escalate_first_fail;
  } msw_supply_t;

  // Decoded watchdog controls
  typedef struct packed {
    logic active;
    logic window_mode;
    logic start_on_bus_wake;
    logic parity_ok;
    logic period_valid;
    logic [9:0] period_ms;
  } msw_wd_t;
endpackage : msw_pkg

// ---- rtl/msw_period_rom.sv ----
// Watchdog period lookup with a registered output.
// Assumes the code input is stable for one clock before its use.
module msw_period_rom (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // Lookup
  input wire logic [2:0] i_code,
  output logic [9:0] o_period_ms,
  output logic o_valid
);
  import msw_pkg::*;

  // ==========================================================================
  // Table
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_period_ms <= 10'h000;
      o_valid <= 1'b0;
    end else begin
      o_valid <= 1'b1;
      unique case (i_code)
        3'h0: o_period_ms <= 10'(MSW_WD_MS_0);
        3'h1: o_period_ms <= 10'(MSW_WD_MS_1);
        3'h2: o_period_ms <= 10'(MSW_WD_MS_2);
        3'h3: o_period_ms <= 10'(MSW_WD_MS_3);
        3'h4: o_period_ms <= 10'(MSW_WD_MS_4);
        3'h5: o_period_ms <= 10'(MSW_WD_MS_5);
        // Unlisted and reserved codes give no period
        default: begin
          o_period_ms <= 10'h000;
          o_valid <= 1'b0;
        end
      endcase
    end
  end
endmodule // msw_period_rom

// ---- testbench/msw_host.sv ----
// Host model: sends one whole 16-bit frame per bench request.
// Assumes the bench raises i_req for a single cycle per frame.
module msw_host
  import msw_pkg::*;
(
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // Bench request
  input wire logic i_req,
  input wire logic i_wr,
  input wire logic i_raw,
  input wire logic [6:0] i_addr,
  input wire logic [7:0] i_data,
  // Frame out
  output logic o_frame_valid,
  output logic [15:0] o_frame
);
  logic [7:0] byte_out;
  // Checksum is filled in for watchdog control bytes unless the bench asks for a raw byte
  assign byte_out = (i_addr == MSW_ADDR_WATCHDOG_CONTROL && !i_raw) ?
    {^i_data[6:0], i_data[6:0]} : i_data;
  // ==========================================================================
  // Frame line inverts itself on every idle cycle between frames
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_frame_valid <= 1'b0;
      o_frame <= 16'h0000;
    end else begin
      o_frame_valid <= i_req;
      o_frame <= i_req ? {i_wr, i_addr, byte_out} : ~o_frame;
    end
  end
endmodule // msw_host

// ---- testbench/msw_regs_asserts.sv ----
// Checker for the mode, supply and watchdog registers.
// Assumes it is bound to msw_regs and sees only its ports.
module msw_regs_asserts
  import msw_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_frame_valid,
  input wire logic [15:0] i_frame,
  input wire logic [7:0] o_read_data,
  input wire logic o_read_valid,
  input wire msw_pkg::msw_events_t i_events,
  input wire msw_pkg::msw_mode_t o_mode,
  input wire msw_pkg::msw_supply_t o_supply,
  input wire logic o_soft_reset,
  input wire logic o_reset_output_pin_n,
  input wire logic o_failure_output_pins,
  input wire logic o_main_overvoltage_flag,
  input wire msw_pkg::msw_wd_t o_wd,
  input wire logic o_wd_bus_wake_start
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  logic par_r;
  wire wr = i_frame_valid && i_frame[15];
  wire mode_wr = wr && i_frame[14:8] == MSW_ADDR_MODE_SUPPLY;
  wire wd_wr = wr && i_frame[14:8] == MSW_ADDR_WATCHDOG_CONTROL;
  // ==========================================================================
  // Parity of the last written watchdog byte
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      par_r <= 1'b1;
    end else if (wd_wr) begin
      par_r <= ~^i_frame[7:0];
    end
  end
  sequence frame_taken; i_frame_valid; endsequence
  sequence answer_seen; o_read_valid; endsequence
  sequence lone_mode_wr; mode_wr && !$past(i_frame_valid); endsequence
  read_strobe_a: assert property (frame_taken |=> answer_seen)
    else $error("no read strobe after frame");
  old_value_a: assert property (lone_mode_wr |=> o_read_data[7:6] ==
    $past(o_mode)) else $error("write did not return old mode");
  stop_sleep_a: assert property (lone_mode_wr and (i_frame[7:6] == 2'b01
    && o_mode == MSW_MODE_STOP && !i_events.restart_entry) |=>
    o_mode == MSW_MODE_STOP) else $error("stop to sleep taken");
  mode_normal_a: assert property (mode_wr && i_frame[7:6] == 2'b00 |->
    ##[1:2] o_mode == MSW_MODE_NORMAL) else $error("normal not set");
  soft_pulse_a: assert property (mode_wr && i_frame[7:6] == 2'b11 |=>
    o_soft_reset) else $error("soft reset not pulsed");
  pin_cause_a: assert property (!o_soft_reset && !$past(i_rst) |->
    o_reset_output_pin_n)
    else $error("reset pin low without soft reset");
  restart_a: assert property ($rose(i_events.restart_entry) |-> ##[1:2]
    (o_mode == MSW_MODE_NORMAL && !o_supply.second_regulator_on))
    else $error("restart did not clear mode");
  overtemp_a: assert property ($rose(i_events.overtemp) |-> ##[1:2]
    !o_supply.second_regulator_on) else $error("overtemp kept on");
  ov_flag_a: assert property (i_events.main_overvoltage |=>
    o_main_overvoltage_flag) else $error("overvoltage flag missing");
  parity_eval_a: assert property (wd_wr ##1 !wd_wr |-> ##1
    o_wd.parity_ok == par_r) else $error("parity flag wrong");
  fail_pin_a: assert property (i_events.failure_active |-> ##[1:2]
    o_failure_output_pins) else $error("failure not shown");
endmodule // msw_regs_asserts

bind msw_regs msw_regs_asserts i_chk (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
  .i_frame_valid(i_frame_valid), .i_frame(i_frame),
  .o_read_data(o_read_data), .o_read_valid(o_read_valid),
  .i_events(i_events), .o_mode(o_mode), .o_supply(o_supply),
  .o_soft_reset(o_soft_reset), .o_reset_output_pin_n(o_reset_output_pin_n),
  .o_failure_output_pins(o_failure_output_pins),
  .o_main_overvoltage_flag(o_main_overvoltage_flag), .o_wd(o_wd),
  .o_wd_bus_wake_start(o_wd_bus_wake_start));

// ---- testbench/mode_supply_watchdog_ctrl_regs_bench.sv ----
// Bench for the mode, supply and watchdog registers.
// Assumes the host model turns one request into one frame.
module mode_supply_watchdog_ctrl_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import msw_pkg::*;
  logic i_ref_clk, i_rst, req, wr, raw, fv, rv, srst, pin_n, fo, ovf, bws;
  logic [6:0] addr;
  logic [7:0] data, rd;
  logic [15:0] frame;
  msw_events_t ev;
  msw_mode_t mode;
  msw_supply_t sup;
  msw_wd_t wd;
  int num_errors, tests_run, cycles;
  logic [10:0] ms_tab [8] = '{{1'b1, 10'd10}, {1'b1, 10'd20}, {1'b1, 10'd50},
    {1'b1, 10'd100}, {1'b1, 10'd200}, {1'b1, 10'd500}, 11'h0, 11'h0};
  msw_host i_host (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_req(req),
    .i_wr(wr), .i_raw(raw), .i_addr(addr), .i_data(data),
    .o_frame_valid(fv), .o_frame(frame));
  msw_regs i_dut (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_frame_valid(fv),
    .i_frame(frame), .o_read_data(rd), .o_read_valid(rv), .i_events(ev),
    .o_mode(mode), .o_supply(sup), .o_soft_reset(srst),
    .o_reset_output_pin_n(pin_n), .o_failure_output_pins(fo),
    .o_main_overvoltage_flag(ovf), .o_wd(wd), .o_wd_bus_wake_start(bws));
  // ==========================================================================
  // Shared tasks
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Pulses of the answer cycle are sampled just before returning
  task automatic xfer(input logic w, input logic [6:0] a, input logic [7:0] d);
    @(posedge i_ref_clk);
    req <= 1'b1;
    wr <= w;
    addr <= a;
    data <= d;
    @(posedge i_ref_clk);
    req <= 1'b0;
    @(posedge i_ref_clk);
    #1;
    chk(rv, 1'b1);
  endtask
  task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp);
    xfer(1'b0, a, 8'h00);
    chk(rd, exp);
  endtask
  task automatic settle;
    repeat (3) @(posedge i_ref_clk);
    #1;
  endtask
  // ==========================================================================
  // Clock, timeout, stimulus
  initial begin
    i_ref_clk = 1'b0;
    forever #20 i_ref_clk = ~i_ref_clk;
  end
  always @(posedge i_ref_clk) begin
    cycles++;
    if (cycles == 2000) begin
      num_errors++;
      wrap_up();
    end
  end
  initial begin
    {i_rst, req, wr, raw, addr, data} = {2'b10, 2'b00, 15'h0};
    ev = '0;
    repeat (10) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    rd_chk(7'h01, 8'h00);
    rd_chk(7'h02, 8'h00);
    rd_chk(7'h03, 8'h14);
    rd_chk(7'h7f, 8'h00);
    xfer(1'b1, 7'h01, 8'h81);
    chk(rd, 8'h00);
    settle;
    chk({mode, sup.reset_threshold_select}, 4'b1001);
    xfer(1'b1, 7'h01, 8'h43);
    chk(rd, 8'h81);
    rd_chk(7'h01, 8'h83);
    xfer(1'b1, 7'h01, 8'h3c);
    settle;
    chk(sup[7:6], 2'b11);
    @(posedge i_ref_clk) ev.main_overvoltage <= 1'b1;
    settle;
    chk(ovf, 1'b1);
    chk(sup.overvoltage_restart_req, 1'b1);
    // Overtemperature plus battery undervoltage, overvoltage gone
    @(posedge i_ref_clk) ev <= 8'h48;
    settle;
    rd_chk(7'h01, 8'h24);
    chk(sup.aux_regulator_on, 1'b0);
    @(posedge i_ref_clk) ev <= 8'h08;
    xfer(1'b1, 7'h02, 8'hff);
    settle;
    chk({sup.aux_regulator_on, fo}, 2'b11);
    chk({sup[5:4], sup.escalate_first_fail}, 3'b111);
    rd_chk(7'h02, 8'hfb);
    @(posedge i_ref_clk) ev <= 8'h00;
    xfer(1'b1, 7'h01, 8'hc0);
    chk({srst, pin_n}, 2'b11);
    rd_chk(7'h02, 8'h88);
    xfer(1'b1, 7'h01, 8'hc0);
    chk({srst, pin_n}, 2'b10);
    xfer(1'b1, 7'h02, 8'h20);
    xfer(1'b1, 7'h01, 8'h80);
    settle;
    chk(fo, 1'b1);
    @(posedge i_ref_clk) ev.restart_entry <= 1'b1;
    settle;
    chk({fo, mode}, 3'b000);
    rd_chk(7'h02, 8'h00);
    @(posedge i_ref_clk) ev <= 8'h04;
    settle;
    chk(fo, 1'b1);
    @(posedge i_ref_clk) ev <= 8'h00;
    settle;
    chk(fo, 1'b0);
    for (int c = 0; c < 8; c++) begin
      xfer(1'b1, 7'h03, {5'b0, c[2:0]});
      settle;
      chk({wd.period_valid, wd.period_ms}, ms_tab[c]);
      chk(wd.parity_ok, 1'b1);
    end
    @(posedge i_ref_clk) raw <= 1'b1;
    xfer(1'b1, 7'h03, 8'h64);
    settle;
    chk({wd.parity_ok, wd.window_mode}, 2'b01);
    @(posedge i_ref_clk) raw <= 1'b0;
    xfer(1'b1, 7'h01, 8'h80);
    xfer(1'b1, 7'h03, 8'h50);
    @(posedge i_ref_clk) ev.bus_wake <= 1'b1;
    settle;
    chk({wd.active, wd.window_mode, wd.start_on_bus_wake, bws},
      4'b0011);
    wrap_up();
  end
endmodule // mode_supply_watchdog_ctrl_regs_bench
